// [tts_params.svh]
// constants of the tachy therapy shock sequencer
// Summary of operation
// - stable fibrillation gets one pacing attempt first
// - normal attempt: charge at once, stop on success
// - early attempt needs option, 16of20, stability, 12of16
// - early attempt: no charge, keep detecting
// - termination after early attempt: no charge, idle
// - persisting fibrillation charges; first shock confirmed
// - four ineffective attempts disable it until follow-up
// - add-stimulus adds one per earlier train; the single train per episode gets none
// - coupling interval before first and second stimulus
// - per-stimulus decrement ramps from second stimulus
// - scan decrement shortens per earlier train; the single train keeps full coupling
// - eight shocks per zone, common shock settings
// - shocks one, two programmable; later ones maximum
// - charge on detected zone with shock programmed
// - confirmation aborts on three of four slow
// - abort while charging stops and dumps energy
// - confirmed fires on tachy interval within 2 s
// - confirmed shock withheld without tachy interval
// - aborted confirmed shock keeps its slot
// - skipped shocks resume from third position
// - unconfirmed syncs to R wave, async after 2 s
// - polarity, waveform options and capped phases
// - both alternate: four-shock polarity/waveform cycle
`ifndef TTS_PARAMS_SVH
`define TTS_PARAMS_SVH
`define TTS_CLK_HZ 50000000
`define TTS_MS_CYC (`TTS_CLK_HZ / 1000)
`define TTS_SYNC_WIN_MS 12'h7D0
`define TTS_MIN_IV_MS 10'h0C8
`define TTS_P1_CAP_MS 5'h17
`define TTS_P2_CAP_MS 5'h11
`define TTS_P2_W2_MS 5'h02
`define TTS_PAUSE_MS 5'h01
`define TTS_MAX_SHOCKS 4'h8
`define TTS_MIN_ENERGY 6'h02
`define TTS_MAX_ENERGY 6'h28
`define TTS_FAIL_LIMIT 3'h4
`endif

// [tts_pkg.sv]
// types shared by the tachy therapy shock sequencer
package tts_pkg;
  // interval zone classification
  typedef enum logic [1:0] {Z_SLOW = 2'h0, Z_LOW = 2'h1, Z_MID = 2'h2, Z_FIB = 2'h3} tts_zone_t;
  // one classified interval with detection flags
  typedef struct packed {
    logic valid;
    tts_zone_t zone;
    logic fib_det;
    logic tachy_det;
    logic term;
    logic stable;
    logic cnt_met;
    logic fib_12of16;
  } tts_iv_t;
  // programmed therapy settings
  typedef struct packed {
    logic early_opt;
    logic prog_16of20;
    logic confirm_on;
    logic [2:0] shock_en;
    logic pol_rev;
    logic pol_alt;
    logic wav2;
    logic wav_alt;
    logic add_stim;
    logic [3:0] stim_cnt;
    logic [5:0] energy1;
    logic [5:0] energy2;
    logic [9:0] coupling_ms;
    logic [7:0] stim_dec_ms;
    logic [7:0] scan_dec_ms;
  } tts_cfg_t;
  // settings of the shock being fired
  typedef struct packed {
    logic [5:0] energy;
    logic polarity_rev;
    logic wave2;
  } tts_shock_t;
  // sequencer states
  typedef enum logic [2:0] {
    S_IDLE = 3'h0, S_TRAIN = 3'h1, S_EWAIT = 3'h2, S_CHARGE = 3'h3,
    S_SYNC = 3'h4, S_PH1 = 3'h5, S_PAUSE = 3'h6, S_PH2 = 3'h7
  } tts_state_t;
  // count of set bits in a four-bit history
  function automatic logic [2:0] tts_pop4(input logic [3:0] v);
    tts_pop4 = {2'h0, v[0]} + {2'h0, v[1]} + {2'h0, v[2]} + {2'h0, v[3]};
  endfunction : tts_pop4
endpackage : tts_pkg

// [tts_train_gen.sv]
// pacing train generator with coupling interval and ramp
`timescale 1ns/10ps
`include "tts_params.svh"
module tts_train_gen (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ms_tick_i,
  input wire logic start_i,
  input wire logic [4:0] count_i,
  input wire logic [9:0] coupling_i,
  input wire logic [7:0] dec_i,
  output logic pace_o,
  output logic busy_o
);
  logic [9:0] iv_reg; // current stimulus interval
  logic [9:0] timer_reg; // ms left to next stimulus
  logic [4:0] left_reg; // stimuli still to deliver
  logic first_reg; // next stimulus is the first
  logic [10:0] dec_next; // interval after decrement

  // shorten but never below the minimum interval
  always_comb begin
    dec_next = {1'b0, iv_reg} - {3'h0, dec_i};
    if (dec_next[10] || dec_next[9:0] < `TTS_MIN_IV_MS) dec_next = {1'b0, `TTS_MIN_IV_MS};
  end

  // train timing
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      iv_reg <= 10'h000;
      timer_reg <= 10'h000;
      left_reg <= 5'h00;
      first_reg <= 1'b0;
      pace_o <= 1'b0;
    end else begin
      pace_o <= 1'b0;
      if (start_i && left_reg == 5'h00) begin
        iv_reg <= coupling_i; // first stimulus after coupling interval
        timer_reg <= coupling_i;
        left_reg <= count_i;
        first_reg <= 1'b1;
      end else if (left_reg != 5'h00 && ms_tick_i) begin
        if (timer_reg <= 10'h001) begin
          pace_o <= 1'b1;
          left_reg <= left_reg - 5'h01;
          first_reg <= 1'b0;
          if (first_reg) begin
            timer_reg <= iv_reg; // second follows at same interval
          end else begin
            iv_reg <= dec_next[9:0]; // ramp from second stimulus on
            timer_reg <= dec_next[9:0];
          end
        end else begin
          timer_reg <= timer_reg - 10'h001;
        end
      end
    end
  end
  assign busy_o = (left_reg != 5'h00);

  a_train_floor: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    busy_o && !first_reg |-> iv_reg >= `TTS_MIN_IV_MS) else $error("train interval under floor");
endmodule : tts_train_gen

// [tts_confirm.sv]
// three-of-four slow interval abort detector
`timescale 1ns/10ps
module tts_confirm (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic clr_i,
  input wire logic iv_valid_i,
  input wire logic slow_i,
  output logic abort_o
);
  logic [3:0] hist_reg; // last four intervals, one means slow
  logic [2:0] seen_reg; // intervals seen, saturates at four

  // history of intervals during charging
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hist_reg <= 4'h0;
      seen_reg <= 3'h0;
    end else if (clr_i) begin
      hist_reg <= 4'h0;
      seen_reg <= 3'h0;
    end else if (iv_valid_i) begin
      hist_reg <= {hist_reg[2:0], slow_i};
      if (seen_reg != 3'h4) seen_reg <= seen_reg + 3'h1;
    end
  end
  // abort on three slow out of four consecutive
  assign abort_o = (tts_pkg::tts_pop4(hist_reg) >= 3'h3) && (seen_reg >= 3'h3);

  a_abort_count: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    clr_i |=> !abort_o) else $error("abort right after a clear");
endmodule : tts_confirm

// [tts_sequencer.sv]
// tachy therapy sequencer: pacing attempt, charge, confirm and fire
`timescale 1ns/10ps
`include "tts_params.svh"
module tts_sequencer #(
  parameter int MS_CYC = `TTS_MS_CYC,
  parameter logic [11:0] SYNC_WIN_MS = `TTS_SYNC_WIN_MS,
  parameter logic [3:0] MAX_SHOCKS = `TTS_MAX_SHOCKS
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire tts_pkg::tts_iv_t iv_i, // one classification per interval
  input wire tts_pkg::tts_cfg_t cfg_i,
  input wire logic followup_i, // follow-up session pulse
  input wire logic charge_done_i, // capacitors reached target
  input wire logic phase_end_i, // cut-off voltage reached in a phase
  output logic pace_o,
  output logic charge_o,
  output logic dump_o,
  output logic fire_o,
  output logic [1:0] phase_o,
  output tts_pkg::tts_shock_t shock_o,
  output logic event_o,
  output logic attempt_off_o
);
  //////////////////////////////////////////////////////////////////////////
  tts_pkg::tts_state_t state_reg; // sequencer state
  logic [15:0] ms_cnt_reg; // cycle divider for the ms tick
  logic ms_tick; // one-cycle ms pulse
  logic [11:0] tmr_reg; // ms timer of sync window and phases
  logic early_reg; // current attempt is the early variant
  logic attempt_used_reg; // attempt already tried this episode
  logic force_conf_reg; // next shock confirms regardless of setting
  logic success_reg; // attempt ended the rhythm
  logic [2:0] fail_reg; // consecutive ineffective attempts
  logic [3:0] slot_reg; // next shock position in zone
  logic skipped_reg; // a confirmed shock was aborted
  logic [1:0] alt_reg; // alternation step of polarity/waveform
  logic [3:0] train_no_reg; // trains delivered this episode
  tts_pkg::tts_zone_t zone_reg; // zone of current shock therapy
  logic conf_act; // confirmation active for this shock
  logic abort; // confirmation abort criterion
  logic train_start;
  logic train_busy;
  logic [4:0] train_cnt;
  logic [10:0] coup_sub;
  logic [9:0] train_coup;
  logic tachy_iv; // interval within a tachy zone
  logic zone_shock; // shock programmed for detected zone
  logic attempt_ok; // pacing attempt allowed now
  logic early_ok; // early variant conditions
  logic shock_req; // detection calls for a shock
  logic [5:0] energy_sel;

  //////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [5:0] tts_clip_e(input logic [5:0] e);
    tts_clip_e = (e < `TTS_MIN_ENERGY) ? `TTS_MIN_ENERGY : (e > `TTS_MAX_ENERGY) ? `TTS_MAX_ENERGY : e;
  endfunction : tts_clip_e

  // one millisecond tick
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ms_cnt_reg <= 16'h0000;
    end else if (ms_cnt_reg == 16'(MS_CYC - 1)) begin
      ms_cnt_reg <= 16'h0000;
    end else begin
      ms_cnt_reg <= ms_cnt_reg + 16'h0001;
    end
  end
  assign ms_tick = (ms_cnt_reg == 16'(MS_CYC - 1));

  //////////////////////////////////////////////////////////////////////////
  // decision terms
  assign tachy_iv = iv_i.valid && (iv_i.zone != tts_pkg::Z_SLOW);
  assign zone_shock = (iv_i.zone != tts_pkg::Z_SLOW) && cfg_i.shock_en[iv_i.zone - 2'h1];
  assign shock_req = iv_i.valid && (iv_i.fib_det || iv_i.tachy_det) && iv_i.cnt_met && zone_shock
                     && slot_reg < MAX_SHOCKS; // budget of eight
  // early variant: option, 16 of 20, stability, 12 of 16
  assign early_ok = cfg_i.early_opt && cfg_i.prog_16of20 && iv_i.stable && iv_i.fib_12of16;
  // attempt only on fibrillation and stability, once
  assign attempt_ok = iv_i.valid && !attempt_off_o && !attempt_used_reg && iv_i.zone == tts_pkg::Z_FIB
                      && iv_i.stable && (cfg_i.early_opt ? early_ok : iv_i.fib_det);
  assign conf_act = cfg_i.confirm_on || force_conf_reg;
  // train length and coupling for successive trains
  assign train_cnt = {1'b0, cfg_i.stim_cnt} + (cfg_i.add_stim ? {1'b0, train_no_reg} : 5'h00);
  assign coup_sub = {1'b0, cfg_i.coupling_ms} - 11'(cfg_i.scan_dec_ms * train_no_reg);
  assign train_coup = (coup_sub[10] || coup_sub[9:0] < `TTS_MIN_IV_MS) ? `TTS_MIN_IV_MS : coup_sub[9:0];
  assign train_start = (state_reg == tts_pkg::S_IDLE) && attempt_ok;

  tts_train_gen u_train (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .ms_tick_i(ms_tick),
    .start_i(train_start),
    .count_i(train_cnt),
    .coupling_i(train_coup),
    .dec_i(cfg_i.stim_dec_ms),
    .pace_o(pace_o),
    .busy_o(train_busy)
  );

  tts_confirm u_conf (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .clr_i(state_reg != tts_pkg::S_CHARGE),
    .iv_valid_i(iv_i.valid && conf_act), // no evaluation without confirmation
    .slow_i(iv_i.zone == tts_pkg::Z_SLOW),
    .abort_o(abort)
  );

  //////////////////////////////////////////////////////////////////////////
  // main sequence
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= tts_pkg::S_IDLE;
      tmr_reg <= 12'h000;
      early_reg <= 1'b0;
      force_conf_reg <= 1'b0;
      success_reg <= 1'b0;
      zone_reg <= tts_pkg::Z_SLOW;
    end else begin
      case (state_reg)
        tts_pkg::S_IDLE: begin
          success_reg <= 1'b0;
          if (attempt_ok) begin
            early_reg <= cfg_i.early_opt; // attempt precedes any shock
            state_reg <= tts_pkg::S_TRAIN;
          end else if (shock_req) begin
            zone_reg <= iv_i.zone;
            state_reg <= tts_pkg::S_CHARGE; // charge on detection
          end
        end
        tts_pkg::S_TRAIN: begin
          if (!train_busy && !train_start) begin
            force_conf_reg <= 1'b1; // shock after attempt is confirmed
            zone_reg <= tts_pkg::Z_FIB;
            // early keeps detecting, normal charges at once
            state_reg <= early_reg ? tts_pkg::S_EWAIT : tts_pkg::S_CHARGE;
          end
        end
        tts_pkg::S_EWAIT: begin
          if (iv_i.valid && iv_i.term) begin
            success_reg <= 1'b1;
            force_conf_reg <= 1'b0;
            state_reg <= tts_pkg::S_IDLE; // stay uncharged, no therapy
          end else if (iv_i.valid && iv_i.fib_det && iv_i.cnt_met) begin
            state_reg <= tts_pkg::S_CHARGE; // persisting fibrillation
          end
        end
        tts_pkg::S_CHARGE: begin
          tmr_reg <= 12'h000;
          if (!early_reg && force_conf_reg && iv_i.valid && iv_i.term) begin
            success_reg <= 1'b1; // attempt worked: interrupt charge
            force_conf_reg <= 1'b0;
            state_reg <= tts_pkg::S_IDLE;
          end else if (conf_act && abort) begin
            force_conf_reg <= 1'b0;
            state_reg <= tts_pkg::S_IDLE; // stop early and dump
          end else if (charge_done_i) begin
            state_reg <= tts_pkg::S_SYNC;
          end
        end
        tts_pkg::S_SYNC: begin
          if (ms_tick) tmr_reg <= tmr_reg + 12'h001;
          if (conf_act ? tachy_iv : iv_i.valid) begin
            tmr_reg <= 12'h000;
            state_reg <= tts_pkg::S_PH1; // fire on tachy interval or R wave
          end else if (tmr_reg >= SYNC_WIN_MS) begin
            tmr_reg <= 12'h000;
            // confirmed: inhibit; unconfirmed: fire asynchronously
            state_reg <= conf_act ? tts_pkg::S_IDLE : tts_pkg::S_PH1;
          end
          if (conf_act && (tachy_iv || tmr_reg >= SYNC_WIN_MS)) force_conf_reg <= 1'b0;
        end
        tts_pkg::S_PH1: begin
          if (ms_tick) tmr_reg <= tmr_reg + 12'h001;
          if (phase_end_i || tmr_reg >= {7'h00, `TTS_P1_CAP_MS}) begin
            tmr_reg <= 12'h000;
            state_reg <= tts_pkg::S_PAUSE; // first phase capped
          end
        end
        tts_pkg::S_PAUSE: begin
          if (ms_tick) tmr_reg <= tmr_reg + 12'h001;
          if (tmr_reg >= {7'h00, `TTS_PAUSE_MS}) begin
            tmr_reg <= 12'h000;
            state_reg <= tts_pkg::S_PH2;
          end
        end
        tts_pkg::S_PH2: begin
          if (ms_tick) tmr_reg <= tmr_reg + 12'h001;
          // second phase capped, fixed for second waveform
          if ((!shock_o.wave2 && phase_end_i)
              || tmr_reg >= {7'h00, shock_o.wave2 ? `TTS_P2_W2_MS : `TTS_P2_CAP_MS}) begin
            tmr_reg <= 12'h000;
            state_reg <= tts_pkg::S_IDLE;
          end
        end
        default: begin
          state_reg <= tts_pkg::S_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // episode bookkeeping: attempt use, train count, shock slots
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      attempt_used_reg <= 1'b0;
      train_no_reg <= 4'h0;
      slot_reg <= 4'h0;
      skipped_reg <= 1'b0;
    end else if (state_reg == tts_pkg::S_IDLE && iv_i.valid && iv_i.term) begin
      attempt_used_reg <= 1'b0; // episode over
      train_no_reg <= 4'h0;
      slot_reg <= 4'h0;
      skipped_reg <= 1'b0;
    end else begin
      if (train_start) begin
        attempt_used_reg <= 1'b1;
        train_no_reg <= train_no_reg + 4'h1;
      end
      // aborted confirmed shock keeps its slot but marks the skip
      if ((state_reg == tts_pkg::S_CHARGE && conf_act && abort)
          || (state_reg == tts_pkg::S_SYNC && conf_act && !tachy_iv && tmr_reg >= SYNC_WIN_MS)) begin
        skipped_reg <= 1'b1;
      end
      // after a skip, resume from the third position
      if (state_reg == tts_pkg::S_IDLE && shock_req && skipped_reg && slot_reg < 4'h2) begin
        slot_reg <= 4'h2;
        skipped_reg <= 1'b0;
      end
      if (fire_o) slot_reg <= slot_reg + 4'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // attempt effectiveness and auto-disable
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fail_reg <= 3'h0;
      attempt_off_o <= 1'b0;
    end else begin
      if (followup_i) begin
        fail_reg <= 3'h0;
        attempt_off_o <= 1'b0; // re-enabled at follow-up
      end else if (success_reg) begin
        fail_reg <= 3'h0;
      end
      // a miss in the cycle of a follow-up still counts: the set wins
      if (fire_o && force_conf_reg == 1'b0 && slot_reg == 4'h0 && attempt_used_reg && !success_reg) begin
        fail_reg <= fail_reg + 3'h1;
        if (fail_reg == `TTS_FAIL_LIMIT - 3'h1) attempt_off_o <= 1'b1; // four misses disable
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // shock energy and alternation
  always_comb begin
    case (slot_reg)
      4'h0: energy_sel = tts_clip_e(cfg_i.energy1); // programmable first
      4'h1: energy_sel = tts_clip_e(cfg_i.energy2); // programmable second
      default: energy_sel = `TTS_MAX_ENERGY; // later ones at maximum
    endcase
  end

  // alternation step advances with each delivered shock
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      alt_reg <= 2'h0;
    end else if (state_reg == tts_pkg::S_IDLE && iv_i.valid && iv_i.term) begin
      alt_reg <= 2'h0;
    end else if (fire_o) begin
      alt_reg <= alt_reg + 2'h1; // wraps after the fourth shock
    end
  end

  // latched shock settings, common per zone
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shock_o <= '0;
    end else if (state_reg == tts_pkg::S_CHARGE) begin
      shock_o.energy <= energy_sel;
      shock_o.polarity_rev <= cfg_i.pol_rev ^ (cfg_i.pol_alt & alt_reg[0]);
      // both alternating: waveform flips every second shock
      shock_o.wave2 <= cfg_i.wav2 ^ (cfg_i.wav_alt & (cfg_i.pol_alt ? alt_reg[1] : alt_reg[0]));
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // output strobes
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fire_o <= 1'b0;
      dump_o <= 1'b0;
      event_o <= 1'b0;
    end else begin
      fire_o <= (state_reg == tts_pkg::S_SYNC) && ((conf_act ? tachy_iv : iv_i.valid)
                || (!conf_act && tmr_reg >= SYNC_WIN_MS));
      // dump on abort or on successful attempt
      dump_o <= (state_reg == tts_pkg::S_CHARGE) && ((conf_act && abort)
                || (!early_reg && force_conf_reg && iv_i.valid && iv_i.term));
      // abort, inhibit, async fire, auto-disable
      event_o <= ((state_reg == tts_pkg::S_CHARGE) && conf_act && abort)
                 || ((state_reg == tts_pkg::S_SYNC) && !(conf_act ? tachy_iv : iv_i.valid)
                     && tmr_reg >= SYNC_WIN_MS)
                 || (fire_o && fail_reg == `TTS_FAIL_LIMIT - 3'h1 && !attempt_off_o
                     && !force_conf_reg && slot_reg == 4'h0 && attempt_used_reg && !success_reg);
    end
  end
  assign charge_o = (state_reg == tts_pkg::S_CHARGE);
  assign phase_o = (state_reg == tts_pkg::S_PH1) ? 2'h1 : (state_reg == tts_pkg::S_PH2) ? 2'h2 : 2'h0;

  //////////////////////////////////////////////////////////////////////////
  // checks
  a_early_nocharge: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    state_reg == tts_pkg::S_EWAIT && !(iv_i.valid && iv_i.fib_det && iv_i.cnt_met) |=> !charge_o)
    else $error("charging while early wait");
  a_term_idle: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    state_reg == tts_pkg::S_EWAIT && iv_i.valid && iv_i.term |=> state_reg == tts_pkg::S_IDLE && !charge_o)
    else $error("therapy after termination");
  a_first_confirmed: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    state_reg == tts_pkg::S_TRAIN && !train_busy |=> conf_act) else $error("shock after attempt not confirmed");
  a_train_then_charge: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $fell(train_busy) && !early_reg |=> charge_o) else $error("no charge after attempt");
  a_abort_dumps: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    charge_o && conf_act && abort |=> dump_o && !charge_o && event_o) else $error("abort not dumped");
  a_late_energy: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    fire_o && slot_reg >= 4'h2 |-> shock_o.energy == `TTS_MAX_ENERGY) else $error("late shock not max");
  a_sync_window: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    state_reg == tts_pkg::S_SYNC |-> tmr_reg <= SYNC_WIN_MS) else $error("sync window overrun");
  a_conf_inhibit: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    state_reg == tts_pkg::S_SYNC && conf_act && !tachy_iv && tmr_reg >= SYNC_WIN_MS
    |=> !fire_o && event_o && state_reg == tts_pkg::S_IDLE) else $error("confirmed shock not withheld");
  a_async_fire: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    state_reg == tts_pkg::S_SYNC && !conf_act && !iv_i.valid && tmr_reg >= SYNC_WIN_MS |=> fire_o && event_o)
    else $error("no async shock");
  a_slot_kept: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    dump_o |-> $stable(slot_reg)) else $error("aborted shock used a slot");
  a_budget: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    fire_o |-> slot_reg < MAX_SHOCKS) else $error("shock beyond zone budget");
  a_alt_cycle: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    fire_o && alt_reg == 2'h3 |=> alt_reg == 2'h0) else $error("alternation did not restart");
endmodule : tts_sequencer

// [tts_hv_model.sv]
// high-voltage stage model answering charge and phase requests
`timescale 1ns/10ps
module tts_hv_model (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic slow_i,
  input wire logic charge_i,
  input wire logic [1:0] phase_i,
  output logic charge_done_o,
  output logic phase_end_o
);
  logic [7:0] ccnt_reg; // cycles spent charging
  logic [3:0] pcnt_reg; // cycles in the present phase
  logic [1:0] pph_reg; // phase seen one cycle ago
  // time the charge and each phase
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ccnt_reg <= 8'h00;
      pcnt_reg <= 4'h0;
      pph_reg <= 2'h0;
    end else begin
      ccnt_reg <= charge_i ? ccnt_reg + 8'h01 : 8'h00;
      pcnt_reg <= (phase_i != 2'h0 && phase_i == pph_reg) ? pcnt_reg + 4'h1 : 4'h0;
      pph_reg <= phase_i;
    end
  end
  // slow mode keeps charging long enough for an abort
  assign charge_done_o = charge_i && (ccnt_reg >= (slow_i ? 8'hC8 : 8'h1E));
  assign phase_end_o = (phase_i != 2'h0) && (pcnt_reg == 4'h3);
endmodule : tts_hv_model

// [testbench.sv]
// self-checking bench of the tachy therapy sequencer
`timescale 1ns/10ps
module testbench;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic slow = 1'b0;
  logic followup = 1'b0;
  logic charge_done, phase_end, pace_o, charge_o, dump_o, fire_o, event_o, attempt_off_o;
  logic [1:0] phase_o;
  logic [5:0] e1;
  tts_pkg::tts_iv_t iv = '0;
  tts_pkg::tts_cfg_t cfg = '0;
  tts_pkg::tts_shock_t shock_o;
  int error_cnt = 0, total_checks = 0, ev_cnt = 0, pace_cnt = 0, c, ev0;
  always #10 ref_clk_i = ~ref_clk_i;
  // tally one-cycle pulses
  always @(posedge ref_clk_i) begin
    if (event_o === 1'b1) ev_cnt++;
    if (pace_o === 1'b1) pace_cnt++;
  end
  tts_sequencer #(.MS_CYC(10), .SYNC_WIN_MS(12'h014), .MAX_SHOCKS(4'h8)) dut (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .iv_i(iv), .cfg_i(cfg), .followup_i(followup), .charge_done_i(charge_done),
    .phase_end_i(phase_end), .pace_o(pace_o), .charge_o(charge_o), .dump_o(dump_o), .fire_o(fire_o),
    .phase_o(phase_o), .shock_o(shock_o), .event_o(event_o), .attempt_off_o(attempt_off_o));
  tts_hv_model hv (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .slow_i(slow), .charge_i(charge_o),
    .phase_i(phase_o), .charge_done_o(charge_done), .phase_end_o(phase_end));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  task tick;
    @(posedge ref_clk_i);
    #1;
  endtask : tick
  // one classified interval, one idle edge before it
  task send(input logic [1:0] z, input logic f, input logic t, input logic trm);
    tick;
    iv = '{1'b1, tts_pkg::tts_zone_t'(z), f, t, trm, 1'b1, 1'b1, 1'b1};
    tick;
    iv.valid = 1'b0;
  endtask : send
  function automatic bit hit(input int k);
    case (k)
      0: hit = charge_o === 1'b1;
      1: hit = fire_o === 1'b1;
      2: hit = dump_o === 1'b1;
      3: hit = phase_o === 2'h2;
      4: hit = charge_done === 1'b1;
      5: hit = phase_o === 2'h0;
      default: hit = pace_cnt == int'(cfg.stim_cnt);
    endcase
  endfunction : hit
  // bounded wait; c returns the cycles spent
  task wait_sig(input int k);
    c = 0;
    while (!hit(k)) begin
      tick;
      c++;
      if (c > 20000) begin
        error_cnt++;
        print_verdict;
      end
    end
  endtask : wait_sig
  initial begin
    void'($urandom(32'hF405));
    e1 = 6'($urandom_range(40, 2));
    cfg.energy1 = e1;
    cfg.energy2 = 6'h28;
    cfg.stim_cnt = 4'($urandom_range(4, 1));
    cfg.coupling_ms = 10'h0C8;
    cfg.shock_en = 3'h4;
    repeat (10) tick;
    rst_n_i = 1'b1;
    tick;
    check({pace_o, charge_o, dump_o, fire_o, event_o}, 32'h0);
    // stable fibrillation: pacing train, then charge and a synced shock
    pace_cnt = 0;
    send(2'h3, 1'b1, 1'b0, 1'b0);
    wait_sig(0);
    check(pace_cnt, {28'h0, cfg.stim_cnt});
    wait_sig(4);
    send(2'h3, 1'b1, 1'b0, 1'b0);
    wait_sig(1);
    check(shock_o.energy, {26'h0, e1});
    wait_sig(3);
    wait_sig(5);
    send(2'h0, 1'b0, 1'b0, 1'b1);
    $display("test attempt done");
    // confirmed charge aborted by three slow intervals
    cfg.confirm_on = 1'b1;
    cfg.shock_en = 3'h1;
    slow = 1'b1;
    ev0 = ev_cnt;
    send(2'h1, 1'b0, 1'b1, 1'b0);
    wait_sig(0);
    check(charge_o, 32'h1);
    repeat (3) send(2'h0, 1'b0, 1'b0, 1'b0);
    wait_sig(2);
    check(c, 32'h1);
    tick;
    check(charge_o, 32'h0);
    check(ev_cnt > ev0, 32'h1);
    send(2'h0, 1'b0, 1'b0, 1'b1);
    slow = 1'b0;
    $display("test abort done");
    // unconfirmed shock goes asynchronous after the sync window
    cfg.confirm_on = 1'b0;
    cfg.shock_en = 3'h2;
    send(2'h2, 1'b0, 1'b1, 1'b0);
    wait_sig(4);
    wait_sig(1);
    check(c >= 190 && c <= 205, 32'h1);
    check(event_o, 32'h1);
    check(shock_o.energy, {26'h0, e1});
    wait_sig(3);
    wait_sig(5);
    send(2'h0, 1'b0, 1'b0, 1'b1);
    $display("test async done");
    // four ineffective attempts turn the attempt off until follow-up
    followup = 1'b1;
    tick;
    followup = 1'b0;
    ev0 = ev_cnt;
    repeat (4) begin
      check(attempt_off_o, 32'h0);
      send(2'h3, 1'b1, 1'b0, 1'b0);
      wait_sig(4);
      send(2'h3, 1'b1, 1'b0, 1'b0);
      wait_sig(1);
      wait_sig(3);
      wait_sig(5);
      send(2'h0, 1'b0, 1'b0, 1'b1);
    end
    check(attempt_off_o, 32'h1);
    check(ev_cnt - ev0, 32'h1);
    followup = 1'b1;
    tick;
    followup = 1'b0;
    check(attempt_off_o, 32'h0);
    $display("test disable done");
    // early attempt: no charge after the train, termination leaves it idle
    cfg.early_opt = 1'b1;
    cfg.prog_16of20 = 1'b1;
    pace_cnt = 0;
    send(2'h3, 1'b1, 1'b0, 1'b0);
    wait_sig(6);
    tick;
    check(charge_o, 32'h0);
    send(2'h0, 1'b0, 1'b0, 1'b1);
    tick;
    check({charge_o, dump_o, fire_o}, 32'h0);
    $display("test early done");
    print_verdict;
  end
endmodule : testbench
